// ==== hw/pmc_map.svh ====
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH
`define PMC_CLK_MHZ 200
`define PMC_ADC_DUTY_PCT 1
`define PMC_ADC_PERIOD 100
`define PMC_ADC_ON_CYCLES (`PMC_ADC_PERIOD * `PMC_ADC_DUTY_PCT / 100)
`define PMC_SENSOR_PERIOD 1000
`define PMC_MHZ_HIGH 240
`define PMC_MHZ_MID 160
`define PMC_MHZ_NORMAL 80
`define PMC_LOAD_HIGH 8'hc0
`define PMC_LOAD_MID 8'h60
`endif

// ==== hw/pmc_pkg.sv ====
package pmc_pkg;
    typedef enum logic [4:0] {
        PMC_ACTIVE = 5'h01,
        PMC_MODEM  = 5'h02,
        PMC_LIGHT  = 5'h04,
        PMC_DEEP   = 5'h08,
        PMC_HIBER  = 5'h10
    } pmc_mode_type;
    typedef enum logic [1:0] {
        PMC_CPU_80  = 2'h0,
        PMC_CPU_160 = 2'h1,
        PMC_CPU_240 = 2'h2
    } pmc_cpu_clk_type;
    typedef struct packed {
        logic radio_on;
        logic baseband_on;
        logic cpu_on;
        logic cpu_clk_en;
        logic rtc_mem_on;
        logic rtc_recovery_mem_on;
        logic rtc_periph_on;
        logic sleep_coprocessor_on;
        logic fast_osc_on;
        logic slow_timer_on;
        logic rtc_gpio_wake_on;
        logic two_wire_on;
        logic retain_link_state;
    } pmc_domains_type;
    typedef struct packed {
        logic mac;
        logic host;
        logic rtc_timer;
        logic ext_irq;
        logic rtc_gpio;
    } pmc_wake_type;
endpackage

// ==== hw/pmc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser per bit.
module pmc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // pmc_sync
`default_nettype wire

// ==== hw/pmc_power_mode_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pmc_map.svh"
module pmc_power_mode_controller #(
    parameter bit MAX_240 = 1'b1,
    parameter int SENSOR_PERIOD = `PMC_SENSOR_PERIOD
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Mode requests from software, same clock
    input wire logic req_valid,
    input wire pmc_pkg::pmc_mode_type req_mode,
    input wire logic wireless_en,
    input wire logic sensor_monitor_en,
    input wire logic clk_auto,
    input wire pmc_pkg::pmc_cpu_clk_type clk_sel,
    input wire logic [7:0] cpu_load,
    input wire logic periph_fast,
    // Wake sources and power pin, asynchronous
    input wire pmc_pkg::pmc_wake_type wake_raw,
    input wire logic power_enable_pin,
    // Status and domain controls
    output pmc_pkg::pmc_mode_type mode,
    output pmc_pkg::pmc_cpu_clk_type cpu_clk,
    output pmc_pkg::pmc_domains_type domains,
    output logic adc_en,
    output logic sensor_tick,
    output logic chip_powered
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    pmc_pkg::pmc_wake_type wake;
    logic pin_on;
    pmc_sync #(.WIDTH(6)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .async_in({wake_raw, power_enable_pin}),
        .sync_out({wake, pin_on})
    );

    // ****************************************
    // Mode state machine
    // ****************************************
    pmc_pkg::pmc_mode_type next_mode;
    logic light_wake, hiber_wake, deep_wake, req_ok;
    always_comb begin
        light_wake = |{wake.mac, wake.host, wake.rtc_timer, wake.ext_irq};
        hiber_wake = wake.rtc_timer | wake.rtc_gpio;
        deep_wake = wake.rtc_timer | wake.ext_irq | wake.rtc_gpio;
        req_ok = req_valid && (req_mode inside {pmc_pkg::PMC_ACTIVE, pmc_pkg::PMC_MODEM,
            pmc_pkg::PMC_LIGHT, pmc_pkg::PMC_DEEP, pmc_pkg::PMC_HIBER});
        next_mode = mode;
        unique case (mode)
            pmc_pkg::PMC_ACTIVE, pmc_pkg::PMC_MODEM: begin
                if (req_ok) begin
                    next_mode = req_mode;
                end
                if (wireless_en && req_ok && !(req_mode inside {pmc_pkg::PMC_ACTIVE, pmc_pkg::PMC_MODEM})) begin
                    next_mode = mode;
                end
            end
            pmc_pkg::PMC_LIGHT: begin
                if (light_wake) begin
                    next_mode = pmc_pkg::PMC_ACTIVE;
                end
            end
            pmc_pkg::PMC_DEEP: begin
                if (deep_wake) begin
                    next_mode = pmc_pkg::PMC_ACTIVE;
                end
            end
            pmc_pkg::PMC_HIBER: begin
                if (hiber_wake) begin
                    next_mode = pmc_pkg::PMC_ACTIVE;
                end
            end
            default: next_mode = pmc_pkg::PMC_ACTIVE;
        endcase
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode <= pmc_pkg::PMC_ACTIVE;
        end else if (!pin_on) begin
            mode <= pmc_pkg::PMC_ACTIVE;
        end else begin
            mode <= next_mode;
        end
    end

    // ****************************************
    // CPU clock selection
    // ****************************************
    pmc_pkg::pmc_cpu_clk_type next_cpu_clk, want_clk;
    always_comb begin
        want_clk = clk_sel;
        if (clk_auto && mode == pmc_pkg::PMC_MODEM) begin
            if (cpu_load >= `PMC_LOAD_HIGH) begin
                want_clk = pmc_pkg::PMC_CPU_240;
            end else if (cpu_load >= `PMC_LOAD_MID || periph_fast) begin
                want_clk = pmc_pkg::PMC_CPU_160;
            end else begin
                want_clk = pmc_pkg::PMC_CPU_80;
            end
        end
        next_cpu_clk = want_clk;
        if (want_clk == pmc_pkg::PMC_CPU_240 && !MAX_240) begin
            next_cpu_clk = pmc_pkg::PMC_CPU_160;
        end else if (!(want_clk inside {pmc_pkg::PMC_CPU_80, pmc_pkg::PMC_CPU_160, pmc_pkg::PMC_CPU_240})) begin
            next_cpu_clk = pmc_pkg::PMC_CPU_80;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cpu_clk <= pmc_pkg::PMC_CPU_80;
        end else begin
            cpu_clk <= next_cpu_clk;
        end
    end

    // ****************************************
    // Domain gating
    // ****************************************
    pmc_pkg::pmc_domains_type next_domains;
    always_comb begin
        next_domains = '0;
        next_domains.slow_timer_on = 1'b1;
        next_domains.rtc_gpio_wake_on = 1'b1;
        unique case (next_mode)
            pmc_pkg::PMC_ACTIVE: begin
                next_domains = '1;
            end
            pmc_pkg::PMC_MODEM: begin
                next_domains = '1;
                next_domains.radio_on = 1'b0;
                next_domains.baseband_on = 1'b0;
                next_domains.retain_link_state = 1'b0;
            end
            pmc_pkg::PMC_LIGHT: begin
                next_domains = '1;
                next_domains.radio_on = 1'b0;
                next_domains.baseband_on = 1'b0;
                next_domains.cpu_clk_en = 1'b0;
                next_domains.retain_link_state = 1'b0;
            end
            pmc_pkg::PMC_DEEP: begin
                next_domains.rtc_mem_on = 1'b1;
                next_domains.rtc_recovery_mem_on = 1'b1;
                next_domains.rtc_periph_on = 1'b1;
                next_domains.sleep_coprocessor_on = 1'b1;
                next_domains.two_wire_on = 1'b1;
                next_domains.retain_link_state = 1'b1;
            end
            pmc_pkg::PMC_HIBER: begin
                next_domains.fast_osc_on = 1'b0;
            end
            default: next_domains = '1;
        endcase
        if (!pin_on) begin
            next_domains = '0;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            domains <= '1;
            chip_powered <= 1'b0;
        end else begin
            domains <= next_domains;
            chip_powered <= pin_on;
        end
    end

    // ****************************************
    // Sensor-monitored deep-sleep
    // ****************************************
    logic [31:0] period_cnt, next_period_cnt;
    logic [7:0] duty_cnt, next_duty_cnt;
    logic next_adc_en, next_sensor_tick, monitoring;
    always_comb begin
        monitoring = mode == pmc_pkg::PMC_DEEP && sensor_monitor_en && domains.sleep_coprocessor_on;
        next_period_cnt = '0;
        next_duty_cnt = '0;
        next_sensor_tick = 1'b0;
        if (monitoring) begin
            next_period_cnt = (period_cnt == 32'(SENSOR_PERIOD - 1)) ? '0 : period_cnt + 32'h1;
            next_sensor_tick = (period_cnt == 32'(SENSOR_PERIOD - 1));
            next_duty_cnt = (duty_cnt == 8'(`PMC_ADC_PERIOD - 1)) ? '0 : duty_cnt + 8'h1;
        end
        next_adc_en = monitoring && (next_duty_cnt < 8'(`PMC_ADC_ON_CYCLES));
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            period_cnt <= '0;
            duty_cnt <= '0;
            adc_en <= 1'b0;
            sensor_tick <= 1'b0;
        end else begin
            period_cnt <= next_period_cnt;
            duty_cnt <= next_duty_cnt;
            adc_en <= next_adc_en;
            sensor_tick <= next_sensor_tick;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    active_radio_on_a: assert property (@(posedge clk) disable iff (!reset_n)
        (mode == pmc_pkg::PMC_ACTIVE && chip_powered) |-> domains.radio_on) else $error("radio off in active");
    modem_radio_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        (mode == pmc_pkg::PMC_MODEM) |-> (!domains.radio_on && !domains.baseband_on && domains.cpu_on))
        else $error("modem-sleep domains wrong");
    light_cpu_paused_a: assert property (@(posedge clk) disable iff (!reset_n)
        (mode == pmc_pkg::PMC_LIGHT && chip_powered) |-> (!domains.cpu_clk_en && domains.sleep_coprocessor_on))
        else $error("light-sleep domains wrong");
    light_wake_exit_a: assert property (@(posedge clk) disable iff (!reset_n)
        (mode == pmc_pkg::PMC_LIGHT && light_wake) |=> mode == pmc_pkg::PMC_ACTIVE) else $error("light wake lost");
    deep_only_rtc_a: assert property (@(posedge clk) disable iff (!reset_n)
        (mode == pmc_pkg::PMC_DEEP && chip_powered) |-> (!domains.cpu_on && domains.rtc_mem_on && domains.two_wire_on))
        else $error("deep-sleep domains wrong");
    hiber_osc_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        (mode == pmc_pkg::PMC_HIBER) |-> (!domains.fast_osc_on && !domains.rtc_recovery_mem_on
        && !domains.sleep_coprocessor_on)) else $error("hibernation domains wrong");
    hiber_stay_a: assert property (@(posedge clk) disable iff (!reset_n)
        (mode == pmc_pkg::PMC_HIBER && !hiber_wake && pin_on) |=> mode == pmc_pkg::PMC_HIBER)
        else $error("hibernation left without wake");
    wireless_alt_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wireless_en && mode inside {pmc_pkg::PMC_ACTIVE, pmc_pkg::PMC_MODEM} && pin_on)
        |=> mode inside {pmc_pkg::PMC_ACTIVE, pmc_pkg::PMC_MODEM}) else $error("wireless mode left");
    clk_cap_a: assert property (@(posedge clk) disable iff (!reset_n)
        !MAX_240 |-> cpu_clk != pmc_pkg::PMC_CPU_240) else $error("240 MHz on limited part");
    adc_duty_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(adc_en) |=> !adc_en) else $error("adc duty too long");
    power_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!pin_on && $past(reset_n)) |=> (domains == '0 && !chip_powered)) else $error("power pin ignored");
    enter_deep_c: cover property (@(posedge clk) disable iff (!reset_n) mode == pmc_pkg::PMC_DEEP);
    hiber_wake_c: cover property (@(posedge clk) disable iff (!reset_n)
        mode == pmc_pkg::PMC_HIBER ##1 mode == pmc_pkg::PMC_ACTIVE);
    light_wake_c: cover property (@(posedge clk) disable iff (!reset_n)
        mode == pmc_pkg::PMC_LIGHT ##1 mode == pmc_pkg::PMC_ACTIVE);
    sensor_tick_c: cover property (@(posedge clk) disable iff (!reset_n) sensor_tick);
endmodule // pmc_power_mode_controller
`default_nettype wire

// ==== tb/pmc_wake_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ***************************************************************
// Wake sources and power pin seen from outside the controller.
// ***************************************************************
module pmc_wake_model #(
    parameter int HOLD = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Commands from the bench
    input wire pmc_pkg::pmc_wake_type fire,
    input wire logic pin_on,
    // Lines into the controller
    output pmc_pkg::pmc_wake_type wake_raw,
    output logic power_enable_pin
);
    logic [3:0] left;
    // A wake line is a level held long enough to pass the synchroniser, then dropped.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_raw <= '0;
            left <= 4'h0;
        end else if (fire != '0) begin
            wake_raw <= fire;
            left <= 4'(HOLD);
        end else if (left > 4'h1) begin
            left <= left - 4'h1;
        end else begin
            left <= 4'h0;
            wake_raw <= '0;
        end
    end
    assign power_enable_pin = pin_on;
endmodule // pmc_wake_model
`default_nettype wire

// ==== tb/power_mode_controller_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller_test;
    localparam int SP = 20;
    typedef struct packed {
        logic [4:0] req;
        logic [12:0] mask;
        logic [12:0] val;
        logic [4:0] wake;
    } pmc_row_type;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    pmc_pkg::pmc_mode_type req_mode = pmc_pkg::PMC_ACTIVE;
    logic wireless_en = 1'b0;
    logic sensor_monitor_en = 1'b0;
    logic clk_auto = 1'b0;
    pmc_pkg::pmc_cpu_clk_type clk_sel = pmc_pkg::PMC_CPU_80;
    logic [7:0] cpu_load = 8'h00;
    logic periph_fast = 1'b0;
    pmc_pkg::pmc_wake_type fire = '0;
    logic pin_on = 1'b1;
    pmc_pkg::pmc_wake_type wake_raw;
    logic power_enable_pin;
    pmc_pkg::pmc_mode_type mode;
    pmc_pkg::pmc_cpu_clk_type cpu_clk;
    pmc_pkg::pmc_domains_type domains;
    logic adc_en;
    logic sensor_tick;
    logic chip_powered;
    pmc_pkg::pmc_cpu_clk_type lim_cpu_clk;
    int n_fail = 0;
    int total_checks = 0;
    int n_adc;
    int n_tick;
    pmc_row_type rows [9];
    pmc_power_mode_controller #(.MAX_240(1'b1), .SENSOR_PERIOD(SP)) dut (.clk(clk), .reset_n(reset_n),
        .req_valid(req_valid), .req_mode(req_mode), .wireless_en(wireless_en),
        .sensor_monitor_en(sensor_monitor_en), .clk_auto(clk_auto), .clk_sel(clk_sel), .cpu_load(cpu_load),
        .periph_fast(periph_fast), .wake_raw(wake_raw), .power_enable_pin(power_enable_pin), .mode(mode),
        .cpu_clk(cpu_clk), .domains(domains), .adc_en(adc_en), .sensor_tick(sensor_tick),
        .chip_powered(chip_powered));
    pmc_wake_model #(.HOLD(4)) far (.clk(clk), .reset_n(reset_n), .fire(fire), .pin_on(pin_on),
        .wake_raw(wake_raw), .power_enable_pin(power_enable_pin));
    // A part limited to 160 MHz shares every input with dut; only its CPU clock is watched.
    pmc_power_mode_controller #(.MAX_240(1'b0), .SENSOR_PERIOD(SP)) dut_limited (.clk(clk), .reset_n(reset_n),
        .req_valid(req_valid), .req_mode(req_mode), .wireless_en(wireless_en),
        .sensor_monitor_en(sensor_monitor_en), .clk_auto(clk_auto), .clk_sel(clk_sel), .cpu_load(cpu_load),
        .periph_fast(periph_fast), .wake_raw(wake_raw), .power_enable_pin(power_enable_pin), .mode(),
        .cpu_clk(lim_cpu_clk), .domains(), .adc_en(), .sensor_tick(), .chip_powered());
    initial begin
        forever #2.5 clk = ~clk;
    end
    // ***************************************************************
    // Drivers and compares.
    // ***************************************************************
    task automatic report_and_stop();
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk_mode(input pmc_pkg::pmc_mode_type got, input pmc_pkg::pmc_mode_type exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: mode %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_val(input logic [12:0] got, input logic [12:0] mask, input logic [12:0] exp);
        total_checks++;
        if ((got & mask) !== exp) begin
            n_fail++;
            $display("mismatch at %0t: value %h mask %h expected %h", $time, got, mask, exp);
        end
    endtask
    task automatic do_req(input logic [4:0] m);
        @(posedge clk);
        req_valid <= 1'b1;
        req_mode <= pmc_pkg::pmc_mode_type'(m);
        @(posedge clk);
        req_valid <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic do_wake(input logic [4:0] w);
        @(posedge clk);
        fire <= w;
        @(posedge clk);
        fire <= '0;
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // ***************************************************************
    // Test sequence.
    // ***************************************************************
    initial begin
        rows = '{'{5'h01, 13'h1000, 13'h1000, 5'h00}, '{5'h02, 13'h1c00, 13'h0400, 5'h00},
            '{5'h04, 13'h0360, 13'h0160, 5'h10}, '{5'h04, 13'h0360, 13'h0160, 5'h08},
            '{5'h04, 13'h0360, 13'h0160, 5'h04}, '{5'h04, 13'h0360, 13'h0160, 5'h02},
            '{5'h08, 13'h1d63, 13'h0163, 5'h04}, '{5'h10, 13'h00bc, 13'h000c, 5'h04},
            '{5'h10, 13'h00bc, 13'h000c, 5'h01}};
        hold(3);
        chk_mode(mode, pmc_pkg::PMC_ACTIVE);
        chk_val({8'h00, cpu_clk, adc_en, sensor_tick, chip_powered}, 13'h001f, 13'h0000);
        chk_val(domains, 13'h1fff, 13'h1fff);
        @(posedge clk);
        reset_n <= 1'b1;
        hold(4);
        chk_val({12'h000, chip_powered}, 13'h0001, 13'h0001);
        for (int i = 0; i < 9; i++) begin
            do_req(rows[i].req);
            chk_mode(mode, pmc_pkg::pmc_mode_type'(rows[i].req));
            chk_val(domains, rows[i].mask, rows[i].val);
            if (rows[i].wake != 5'h00) begin
                do_wake(rows[i].wake);
            end else begin
                do_req(5'h01);
            end
            chk_mode(mode, pmc_pkg::PMC_ACTIVE);
        end
        @(posedge clk);
        wireless_en <= 1'b1;
        do_req(5'h04);
        chk_mode(mode, pmc_pkg::PMC_ACTIVE);
        do_req(5'h02);
        chk_mode(mode, pmc_pkg::PMC_MODEM);
        do_req(5'h01);
        @(posedge clk);
        wireless_en <= 1'b0;
        do_req(5'h03);
        chk_mode(mode, pmc_pkg::PMC_ACTIVE);
        do_req(5'h04);
        do_req(5'h08);
        chk_mode(mode, pmc_pkg::PMC_LIGHT);
        do_wake(5'h08);
        do_req(5'h10);
        do_wake(5'h1a);
        chk_mode(mode, pmc_pkg::PMC_HIBER);
        do_wake(5'h04);
        chk_mode(mode, pmc_pkg::PMC_ACTIVE);
        @(posedge clk);
        clk_auto <= 1'b1;
        cpu_load <= 8'hc0;
        do_req(5'h02);
        hold(3);
        chk_val({11'h000, cpu_clk}, 13'h0003, 13'h0002);
        chk_val({11'h000, lim_cpu_clk}, 13'h0003, 13'h0001);
        @(posedge clk);
        cpu_load <= 8'h60;
        hold(4);
        chk_val({11'h000, cpu_clk}, 13'h0003, 13'h0001);
        @(posedge clk);
        cpu_load <= 8'h00;
        hold(4);
        chk_val({11'h000, cpu_clk}, 13'h0003, 13'h0000);
        @(posedge clk);
        periph_fast <= 1'b1;
        hold(4);
        chk_val({11'h000, cpu_clk}, 13'h0003, 13'h0001);
        @(posedge clk);
        periph_fast <= 1'b0;
        clk_auto <= 1'b0;
        clk_sel <= pmc_pkg::PMC_CPU_160;
        hold(4);
        chk_val({11'h000, cpu_clk}, 13'h0003, 13'h0001);
        @(posedge clk);
        clk_sel <= pmc_pkg::PMC_CPU_240;
        hold(4);
        chk_val({11'h000, cpu_clk}, 13'h0003, 13'h0002);
        chk_val({11'h000, lim_cpu_clk}, 13'h0003, 13'h0001);
        @(posedge clk);
        clk_sel <= pmc_pkg::pmc_cpu_clk_type'(2'h3);
        hold(4);
        chk_val({11'h000, cpu_clk}, 13'h0003, 13'h0000);
        do_req(5'h01);
        @(posedge clk);
        sensor_monitor_en <= 1'b1;
        do_req(5'h08);
        hold(10);
        n_adc = 0;
        n_tick = 0;
        repeat (200) begin
            hold(1);
            n_adc += int'(adc_en);
            n_tick += int'(sensor_tick);
        end
        chk_val(13'(n_adc), 13'h1fff, 13'h0002);
        chk_val(13'(n_tick), 13'h1fff, 13'(200 / SP));
        do_wake(5'h04);
        @(posedge clk);
        sensor_monitor_en <= 1'b0;
        do_req(5'h04);
        @(posedge clk);
        pin_on <= 1'b0;
        hold(4);
        chk_val({12'h000, chip_powered}, 13'h0001, 13'h0000);
        chk_val(domains, 13'h1fff, 13'h0000);
        chk_mode(mode, pmc_pkg::PMC_ACTIVE);
        @(posedge clk);
        pin_on <= 1'b1;
        hold(4);
        chk_val({12'h000, chip_powered}, 13'h0001, 13'h0001);
        chk_val(domains, 13'h1fff, 13'h1fff);
        do_req(5'h10);
        @(posedge clk);
        reset_n <= 1'b0;
        hold(2);
        chk_mode(mode, pmc_pkg::PMC_ACTIVE);
        chk_val(domains, 13'h1fff, 13'h1fff);
        @(posedge clk);
        reset_n <= 1'b1;
        hold(4);
        chk_val({12'h000, chip_powered}, 13'h0001, 13'h0001);
        chk_mode(mode, pmc_pkg::PMC_ACTIVE);
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
endmodule // power_mode_controller_test
`default_nettype wire
